// *** hdl/can_lin_xcvr_irq_enable.sv ***
// Transceiver interrupt enables, pending flags and mode-dependent registers
// Functional notes
// - Enable bits 7:5 written zero, read zero
// - Bit 4 gates bus-silence interrupt
// - Bit 3 gates second LIN wake interrupt
// - Bit 2 gates first LIN wake interrupt
// - Bit 1 gates CAN failure interrupt
// - Bit 0 gates CAN wake interrupt
// - Single-LIN variant: bit 3 reserved
// - Off/fail-safe entry reloads enables, flags, mode field; off also shutdown config
// - Standby reads fault and supply status zero
// - Normal transceiver state follows mode field, except shutdown (config nonzero, field not reset) forces off; standby: listen-only or offline
// - Forced normal: no access, reads zero
// - Enable byte decoded at 23h
// - Enables pair with pending byte at 63h
`include "xcvr_defines.svh"

module can_lin_xcvr_irq_enable
  import xcvr_pkg::*;
#(
  parameter int LIN_CHANNELS = 2
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  sbc_mode_t        sbc_mode,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [6:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        bus_silence_evt,
  input  wire logic        lin_b_wake_evt,
  input  wire logic        lin_a_wake_evt,
  input  wire logic        can_fault_evt,
  input  wire logic        can_wake_evt,
  input  wire logic        bus_silence_timer_state,
  input  wire logic        can_fault_state,
  input  wire logic        can_supply_low,
  input  wire logic        can_shutdown_cond,
  output xcvr_state_t      xcvr_state,
  output logic             xcvr_irq
);

  function automatic logic reinit_mode(input sbc_mode_t m);
    return (m == mode_off) || (m == mode_fail_safe);
  endfunction

  function automatic xcvr_state_t state_of(input sbc_mode_t m,
                                           input logic [1:0] xcvr_mode_field,
                                           input logic shut);
    xcvr_state_t s;
    s = xcvr_offline;
    unique case (m)
      mode_off, mode_overload: s = xcvr_off;
      mode_forced_normal:      s = xcvr_active;
      mode_standby:
        s = (xcvr_mode_field == `CMC_LISTEN) ? xcvr_listen_only : xcvr_offline;
      mode_normal: begin
        if (shut && xcvr_mode_field != `CMC_RST) begin
          s = xcvr_off;
        end else if (xcvr_mode_field == `CMC_LISTEN) begin
          s = xcvr_listen_only;
        end else if (xcvr_mode_field != `CMC_RST) begin
          s = xcvr_active;
        end else begin
          s = xcvr_offline;
        end
      end
      mode_sleep, mode_rst, mode_fail_safe: s = xcvr_offline;
    endcase
    return s;
  endfunction

  localparam logic [4:0] LANES =
    (LIN_CHANNELS > 1) ? `LANES_ALL : `LANES_ONE_LIN;

  mode_evt_if mev ();

  logic [4:0]  en_q;
  logic [4:0]  pend_q;
  logic [4:0]  evt;
  logic [4:0]  pend_clr;
  logic [1:0]  cmc_q;
  logic [1:0]  csc_q;
  logic        fn;
  logic        reload;
  logic        fsp_entry;
  logic        off_entry;
  logic        wr_ok;
  logic [7:0]  rd_d;
  logic        stby;
  logic [4:0]  hit;

  mode_entry u_mode (
    .clk     (clk),
    .arst_n  (arst_n),
    .mode_in (sbc_mode),
    .mev     (mev.src)
  );

  assign fn        = (sbc_mode == mode_forced_normal);
  assign stby      = (sbc_mode == mode_standby);
  assign reload    = mev.entry && reinit_mode(mev.mode);
  assign fsp_entry = mev.entry && (mev.mode == mode_fail_safe);
  assign off_entry = mev.entry && (mev.mode == mode_off);
  assign wr_ok     = reg_wr && !fn;

  // Event lanes, bit 3 only present with two LIN channels
  assign evt = {bus_silence_evt, lin_b_wake_evt, lin_a_wake_evt,
                can_fault_evt, can_wake_evt} & LANES;

  assign pend_clr = (wr_ok && reg_addr == `ADDR_IRQ_PEND) ?
                    (reg_wdata[4:0] & LANES) : 5'h00;

  pend_flags #(.W(5)) u_pend (
    .clk     (clk),
    .arst_n  (arst_n),
    .init    (reload),
    .set     (evt),
    .clr     (pend_clr),
    .flags_q (pend_q)
  );

  // Enable byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      en_q <= `EN_RST;
    end else if (fsp_entry) begin
      en_q <= `EN_FSP;
    end else if (off_entry) begin
      en_q <= `EN_RST;
    end else if (wr_ok && reg_addr == `ADDR_IRQ_EN) begin
      en_q <= reg_wdata[4:0] & LANES;
    end
  end

  // Transceiver control: mode field and shutdown configuration
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmc_q <= `CMC_RST;
      csc_q <= `CSC_RST;
    end else if (off_entry) begin
      cmc_q <= `CMC_RST;
      csc_q <= `CSC_RST;
    end else if (fsp_entry) begin
      cmc_q <= `CMC_RST;
    end else if (wr_ok && reg_addr == `ADDR_XCVR_CTRL) begin
      cmc_q <= reg_wdata[`CTRL_CMC_LSB +: 2];
      csc_q <= reg_wdata[`CTRL_CSC_LSB +: 2];
    end
  end

  // Read multiplexer
  always_comb begin
    rd_d = 8'h00;
    if (!fn) begin
      unique case (reg_addr)
        `ADDR_IRQ_EN:   rd_d = {3'h0, en_q};
        `ADDR_IRQ_PEND: rd_d = {3'h0, pend_q};
        `ADDR_XCVR_CTRL: begin
          rd_d[`CTRL_CMC_LSB +: 2] = cmc_q;
          rd_d[`CTRL_CSC_LSB +: 2] = csc_q;
        end
        `ADDR_XCVR_STAT: begin
          rd_d[`STAT_SILENCE] = bus_silence_timer_state;
          rd_d[`STAT_SUPPLY]  = can_supply_low && !stby;
          rd_d[`STAT_FAULT]   = can_fault_state && !stby;
        end
        default: rd_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_d;
    end
  end

  // Each pending flag gated by its own enable
  assign hit[`BIT_SILENCE] = pend_q[`BIT_SILENCE]
                             & en_q[`BIT_SILENCE];
  assign hit[`BIT_LIN_B]   = pend_q[`BIT_LIN_B]
                             & en_q[`BIT_LIN_B];
  assign hit[`BIT_LIN_A]   = pend_q[`BIT_LIN_A]
                             & en_q[`BIT_LIN_A];
  assign hit[`BIT_FAULT]   = pend_q[`BIT_FAULT]
                             & en_q[`BIT_FAULT];
  assign hit[`BIT_WAKE]    = pend_q[`BIT_WAKE]
                             & en_q[`BIT_WAKE];

  // Interrupt request: any pending flag whose enable is set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      xcvr_irq <= 1'b0;
    end else begin
      xcvr_irq <= |hit;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      xcvr_state <= xcvr_off;
    end else begin
      xcvr_state <= state_of(sbc_mode, cmc_q,
                             can_shutdown_cond && csc_q != 2'h0);
    end
  end

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_irq_raise: assert property (
    (|(pend_q & en_q)) |=> xcvr_irq
  ) else $error("irq missing for enabled pending flag");

  a_irq_masked: assert property (
    !(|(pend_q & en_q)) |=> !xcvr_irq
  ) else $error("irq raised with nothing enabled pending");

  a_en_write: assert property (
    (wr_ok && reg_addr == `ADDR_IRQ_EN && !mev.entry)
      |=> en_q == ($past(reg_wdata[4:0]) & LANES)
  ) else $error("enable byte write not stored");

  a_fn_locked: assert property (
    fn |=> $stable(en_q) && $stable(cmc_q)
  ) else $error("register changed in forced normal");

  a_fn_read_zero: assert property (
    (reg_rd && fn) |=> reg_rdata == 8'h00
  ) else $error("forced normal read not zero");

  a_set_wins: assert property (
    !reload |=> (pend_q & $past(evt)) == $past(evt)
  ) else $error("pending event lost");

  a_fsp_reload: assert property (
    fsp_entry |=> en_q == `EN_FSP && pend_q == `PEND_RST
                  && cmc_q == `CMC_RST ##1 !xcvr_irq
  ) else $error("fail-safe defaults wrong");

  a_lin_b_rsvd: assert property (
    (LIN_CHANNELS > 1) || (!en_q[3] && !pend_q[3])
  ) else $error("second LIN bit used in single LIN variant");

  a_stby_status: assert property (
    (reg_rd && stby && reg_addr == `ADDR_XCVR_STAT)
      |=> reg_rdata[1:0] == 2'b00
  ) else $error("standby status not shown as zero");

  a_rsv_read: assert property (
    (reg_rd && reg_addr == `ADDR_IRQ_EN) |=> reg_rdata[7:5] == 3'h0
  ) else $error("reserved enable bits not zero");

  a_stby_listen: assert property (
    (stby && cmc_q == `CMC_LISTEN) |=> xcvr_state == xcvr_listen_only
  ) else $error("standby listen-only state wrong");

  a_off_reload: assert property (
    off_entry |=> en_q == `EN_RST && pend_q == `PEND_RST
                  && cmc_q == `CMC_RST && csc_q == `CSC_RST
  ) else $error("power-on defaults not reloaded");

  a_en_hold: assert property (
    (mev.entry && !fsp_entry && !off_entry && !wr_ok) |=> $stable(en_q)
  ) else $error("enable byte changed on plain mode entry");

  a_clr_flag: assert property (
    (wr_ok && reg_addr == `ADDR_IRQ_PEND && !reload)
      |=> (pend_q & $past(pend_clr & ~evt)) == 5'h00
  ) else $error("pending flag not cleared by write");

  a_norm_shut: assert property (
    (sbc_mode == mode_normal && can_shutdown_cond && csc_q != 2'h0
     && cmc_q != `CMC_RST) |=> xcvr_state == xcvr_off
  ) else $error("normal mode shutdown state wrong");

  a_stat_live: assert property (
    (reg_rd && !stby && !fn && reg_addr == `ADDR_XCVR_STAT)
      |=> reg_rdata[1:0] == $past({can_supply_low, can_fault_state})
  ) else $error("status bits not live outside standby");

  a_csc_fsp: assert property (
    fsp_entry |=> $stable(csc_q)
  ) else $error("shutdown config changed on fail-safe entry");

  a_rdata_hold: assert property (
    !reg_rd |=> $stable(reg_rdata)
  ) else $error("read data changed without a read");

  c_fsp_entry: cover property (fsp_entry ##1 en_q == `EN_FSP);
  c_off_entry: cover property (off_entry);
  c_irq_rise:  cover property (!xcvr_irq ##1 xcvr_irq);
  c_fn_read:   cover property (reg_rd && fn);
  c_set_clr:   cover property (|(evt & pend_clr));

endmodule

// *** include/xcvr_defines.svh ***
// Register offsets, field positions, reset values for the transceiver block
`ifndef XCVR_DEFINES_SVH
`define XCVR_DEFINES_SVH

`define ADDR_XCVR_CTRL  7'h20
`define ADDR_XCVR_STAT  7'h22
`define ADDR_IRQ_EN     7'h23
`define ADDR_IRQ_PEND   7'h63

`define BIT_SILENCE     4
`define BIT_LIN_B       3
`define BIT_LIN_A       2
`define BIT_FAULT       1
`define BIT_WAKE        0

`define STAT_SILENCE    3
`define STAT_SUPPLY     1
`define STAT_FAULT      0

`define CTRL_CMC_LSB    0
`define CTRL_CSC_LSB    4

`define EN_RST          5'h00
`define EN_FSP          5'h01
`define PEND_RST        5'h00
`define CMC_RST         2'h0
`define CSC_RST         2'h1
`define CMC_LISTEN      2'h3
`define LANES_ALL       5'h1f
`define LANES_ONE_LIN   5'h17

`endif

// *** include/xcvr_pkg.sv ***
// Types shared by the transceiver interrupt-enable modules
package xcvr_pkg;
  typedef enum logic [2:0] {
    mode_off,
    mode_forced_normal,
    mode_standby,
    mode_normal,
    mode_sleep,
    mode_rst,
    mode_overload,
    mode_fail_safe
  } sbc_mode_t;

  typedef enum logic [1:0] {
    xcvr_off,
    xcvr_offline,
    xcvr_listen_only,
    xcvr_active
  } xcvr_state_t;
endpackage

// *** include/mode_evt_if.sv ***
// Mode-entry event carried from the mode tracker to the register logic
interface mode_evt_if;
  import xcvr_pkg::*;
  logic      entry;
  sbc_mode_t mode;
  modport src (output entry, output mode);
  modport dst (input entry, input mode);
endinterface

// *** hdl/mode_entry.sv ***
// Detects entry into a new operating mode
module mode_entry
  import xcvr_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  arst_n,
  input  sbc_mode_t  mode_in,
  mode_evt_if.src    mev
);
  sbc_mode_t mode_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= mode_off;
    end else begin
      mode_q <= mode_in;
    end
  end

  assign mev.entry = (mode_in != mode_q);
  assign mev.mode  = mode_in;
endmodule

// *** hdl/pend_flags.sv ***
// Sticky pending flags: set wins over clear, mode reload wins over both
module pend_flags #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         init,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  output logic      [W-1:0] flags_q
);
  for (genvar i = 0; i < W; i++) begin : g_flag
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        flags_q[i] <= 1'b0;
      end else if (init) begin
        flags_q[i] <= 1'b0;
      end else if (set[i]) begin
        flags_q[i] <= 1'b1;
      end else if (clr[i]) begin
        flags_q[i] <= 1'b0;
      end
    end
  end
endmodule

// *** testbench/host_model.sv ***
// Host microcontroller model driving the register port
module host_model (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [6:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= (a == 7'h23 || a == 7'h63) ? (d & 8'h1f) : d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// *** testbench/can_lin_xcvr_irq_enable_tb.sv ***
// Self-checking bench for the transceiver interrupt-enable block
module can_lin_xcvr_irq_enable_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import xcvr_pkg::*;

  logic        clk, arst_n, reg_wr, reg_rd, irq, irq1;
  logic        tmr, fst, sup, shut;
  logic [6:0]  addr;
  logic [7:0]  wdata, rdata, rdata1, v, r;
  logic [4:0]  evt;
  sbc_mode_t   mode;
  xcvr_state_t xst;
  int          error_cnt, tests_run, cyc;

  host_model h (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata));

  can_lin_xcvr_irq_enable dut (.clk(clk), .arst_n(arst_n),
    .sbc_mode(mode), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .bus_silence_evt(evt[4]),
    .lin_b_wake_evt(evt[3]), .lin_a_wake_evt(evt[2]),
    .can_fault_evt(evt[1]), .can_wake_evt(evt[0]),
    .bus_silence_timer_state(tmr), .can_fault_state(fst),
    .can_supply_low(sup), .can_shutdown_cond(shut),
    .xcvr_state(xst), .xcvr_irq(irq));

  // Single-LIN variant on the same stimulus
  can_lin_xcvr_irq_enable #(.LIN_CHANNELS(1)) dut_one (.clk(clk),
    .arst_n(arst_n), .sbc_mode(mode), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata1),
    .bus_silence_evt(evt[4]), .lin_b_wake_evt(evt[3]),
    .lin_a_wake_evt(evt[2]), .can_fault_evt(evt[1]),
    .can_wake_evt(evt[0]), .bus_silence_timer_state(tmr),
    .can_fault_state(fst), .can_supply_low(sup),
    .can_shutdown_cond(shut), .xcvr_state(), .xcvr_irq(irq1));

  function automatic logic [7:0] lane_mask(input int lins);
    return (lins > 1) ? 8'h1f : 8'h17;
  endfunction

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input string n, input logic [7:0] s,
                       input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic fire(input int b);
    @(posedge clk);
    evt[b] <= 1'b1;
    @(posedge clk);
    evt    <= 5'h00;
    @(posedge clk);
    #1;
  endtask

  task automatic go(input sbc_mode_t m);
    @(posedge clk);
    mode <= m;
    repeat (3) @(posedge clk);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    arst_n = 1'b0;
    mode   = mode_standby;
    evt    = 5'h00;
    {tmr, fst, sup, shut} = 4'h0;
    void'($urandom(13018));
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    h.rd(7'h23, v);
    check("en_reset", v, 8'h00);
    h.rd(7'h63, v);
    check("pend_reset", v, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = 8'($urandom);
      h.wr(7'h23, r);
      h.rd(7'h23, v);
      check("en_rw", v, r & lane_mask(2));
      check("en_rw_one_lin", rdata1, r & lane_mask(1));
    end
    for (int b = 0; b < 5; b++) begin
      h.wr(7'h63, 8'h1f);
      h.wr(7'h23, 8'h01 << b);
      fire(b);
      check("irq_on", {7'h00, irq}, 8'h01);
      check("irq_one_lin", {7'h00, irq1}, {7'h00, b != 3});
      h.rd(7'h63, v);
      check("pend", v, 8'h01 << b);
      check("pend_one_lin", rdata1, (8'h01 << b) & 8'h17);
      h.wr(7'h63, 8'h01 << b);
      @(posedge clk);
      #1;
      check("irq_clr", {7'h00, irq}, 8'h00);
      h.wr(7'h23, ~(8'h01 << b));
      fire(b);
      check("irq_mask", {7'h00, irq}, 8'h00);
    end
    fork
      h.wr(7'h63, 8'h01);
      fire(0);
    join
    h.rd(7'h63, v);
    check("set_wins", v & 8'h01, 8'h01);
    go(mode_fail_safe);
    h.rd(7'h23, v);
    check("fs_en", v, 8'h01);
    h.rd(7'h63, v);
    check("fs_pend", v, 8'h00);
    go(mode_standby);
    h.wr(7'h23, 8'h1f);
    go(mode_forced_normal);
    h.rd(7'h23, v);
    check("fn_read", v, 8'h00);
    h.wr(7'h23, 8'h00);
    go(mode_standby);
    h.rd(7'h23, v);
    check("fn_write", v, 8'h1f);
    @(posedge clk);
    {tmr, fst, sup} <= 3'h7;
    h.rd(7'h22, v);
    check("stby_stat", v & 8'h0b, 8'h08);
    h.wr(7'h20, 8'h13);
    repeat (2) @(posedge clk);
    #1;
    check("stby_listen", {6'h00, xst}, {6'h00, xcvr_listen_only});
    @(posedge clk);
    shut <= 1'b1;
    go(mode_normal);
    #1;
    check("norm_shut", {6'h00, xst}, {6'h00, xcvr_off});
    h.rd(7'h22, v);
    check("norm_stat", v & 8'h0b, 8'h0b);
    go(mode_sleep);
    h.rd(7'h20, v);
    check("sleep_keep", v, 8'h13);
    check("sleep_state", {6'h00, xst}, {6'h00, xcvr_offline});
    go(mode_off);
    h.rd(7'h20, v);
    check("off_ctrl", v, 8'h10);
    test_done();
  end
endmodule
